// ==== pkg/ledic_params.svh ====
// register offsets, field positions, reset values and timing counts for the led indicator
`ifndef LEDIC_PARAMS_SVH
`define LEDIC_PARAMS_SVH

// ----------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------
`define LEDIC_IDX_FUNC 6'h10
`define LEDIC_IDX_POL 6'h11
`define LEDIC_IDX_TMR 6'h12

// ----------------------------------------
// field positions
// ----------------------------------------
`define LEDIC_FN0_LSB 0
`define LEDIC_FN1_LSB 4
`define LEDIC_MIX0_LSB 8
`define LEDIC_MIX1_LSB 12
`define LEDIC_FORCE_INT_BIT 15
`define LEDIC_STRETCH_LSB 12
`define LEDIC_INTPOL_BIT 11
`define LEDIC_BLINK_LSB 8
`define LEDIC_SPD_OFF_LSB 2
`define LEDIC_SPD_ON_LSB 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define LEDIC_RST_POL 8'h00
`define LEDIC_RST_STRETCH 3'h4
`define LEDIC_RST_SPD 2'h1
`define LEDIC_RST_FN1 4'h1
`define LEDIC_MIX_FULL 4'h8

// ----------------------------------------
// timing
// ----------------------------------------
`define LEDIC_CLK_NS 100
`define LEDIC_MS_NS 1000000
`define LEDIC_MS_CYCLES (`LEDIC_MS_NS / `LEDIC_CLK_NS)

`endif

// ==== pkg/ledic_pkg.sv ====
// types shared by the led indicator design
package ledic_pkg;

	// ----------------------------------------
	// led function codes
	// ----------------------------------------
	typedef enum logic [3:0] {
		FN_LINK = 4'b0000,
		FN_LINK_ACT = 4'b0001,
		FN_SPEED_BURST = 4'b0010,
		FN_ACT_ON = 4'b0011,
		FN_ACT_BLINK = 4'b0100,
		FN_TX_ON = 4'b0101,
		FN_COPPER = 4'b0110,
		FN_GIG = 4'b0111,
		FN_FORCE_OFF = 4'b1000,
		FN_FORCE_BLINK = 4'b1001,
		FN_DUAL1 = 4'b1100,
		FN_DUAL2 = 4'b1110,
		FN_DUAL4 = 4'b1111
	} ledic_fn_e;

	// ----------------------------------------
	// speed burst sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {
		SB_IDLE = 2'b00,
		SB_ON = 2'b01,
		SB_OFF = 2'b10,
		SB_GAP = 2'b11
	} ledic_burst_e;

	typedef logic [11:0] ledic_ms_t;

endpackage

// ==== rtl/ledic_tick_gen.sv ====
// millisecond enable pulse divided from the core clock
`timescale 1ns/10ps
module ledic_tick_gen
	import ledic_pkg::*;
#(
	parameter int MS_CYCLES = 10000
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// control
	input wire logic restart,
	// tick
	output logic msTick
);

	logic [15:0] div_ff;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_ff <= 16'h0000;
		end else if (restart || div_ff == 16'(MS_CYCLES - 1)) begin
			div_ff <= 16'h0000;
		end else begin
			div_ff <= div_ff + 16'h0001;
		end
	end

	assign msTick = !restart && div_ff == 16'(MS_CYCLES - 1);

endmodule

// ==== rtl/ledic_ms_timer.sv ====
// retriggerable down counter of millisecond ticks
`timescale 1ns/10ps
module ledic_ms_timer
	import ledic_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// control
	input wire logic msTick,
	input wire logic start,
	input wire ledic_ms_t period,
	// status
	output logic busy,
	output logic done
);

	ledic_ms_t cnt_ff;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= 12'h000;
		end else if (start) begin
			cnt_ff <= period;
		end else if (msTick && cnt_ff != 12'h000) begin
			cnt_ff <= cnt_ff - 12'h001;
		end
	end

	assign busy = cnt_ff != 12'h000;
	// done must not look at start: callers restart the timer from done
	assign done = msTick && cnt_ff == 12'h001;

endmodule

// ==== rtl/ledic_core.sv ====
// led indicator control: registers, function decode, timers and pin drive
// ----------------------------------------
// ----------------------------------------
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "ledic_params.svh"
module ledic_core
	import ledic_pkg::*;
#(
	parameter int MS_CYCLES = `LEDIC_MS_CYCLES,
	parameter int NUM_LEDS = 2
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic swRst,
	// straps
	input wire logic [1:0] ledConfigStrap,
	input wire logic irqPolarityStrap,
	// link state
	input wire logic linkUp,
	input wire logic linkCopper,
	input wire logic [1:0] linkSpeed,
	input wire logic rxActive,
	input wire logic txActive,
	input wire logic phyIrqReq,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// led pins
	output logic [NUM_LEDS-1:0] ledOut,
	output logic [NUM_LEDS-1:0] ledOe,
	// interrupt pins
	output logic phyIrqOutHigh,
	output logic phyIrqOutLow
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [3:0] led0Fn_ff;
	logic [3:0] led1Fn_ff;
	logic [3:0] mix0_ff;
	logic [3:0] mix1_ff;
	logic [7:0] ledPol_ff;
	logic forceInt_ff;
	logic [2:0] stretch_ff;
	logic irqPol_ff;
	logic [2:0] blinkRate_ff;
	logic [1:0] spdOff_ff;
	logic [1:0] spdOn_ff;
	logic strapLoad_ff;
	logic ack_ff;
	logic [31:0] rdData_ff;

	logic wbReq;
	logic wbWrite;
	logic selFunc;
	logic selPol;
	logic selTmr;

	assign wbReq = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wbWrite = wbReq && wb_we_i;
	assign selFunc = wb_adr_i[7:2] == `LEDIC_IDX_FUNC;
	assign selPol = wb_adr_i[7:2] == `LEDIC_IDX_POL;
	assign selTmr = wb_adr_i[7:2] == `LEDIC_IDX_TMR;

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wbReq;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData_ff <= 32'h0000_0000;
		end else if (wbReq && !wb_we_i) begin
			rdData_ff <= 32'h0000_0000;
			if (selFunc) begin
				rdData_ff[7:0] <= {led1Fn_ff, led0Fn_ff};
			end else if (selPol) begin
				rdData_ff[15:0] <= {mix1_ff, mix0_ff, ledPol_ff};
			end else if (selTmr) begin
				rdData_ff[15:0] <= {forceInt_ff, stretch_ff, irqPol_ff, blinkRate_ff,
					4'h0, spdOff_ff, spdOn_ff};
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdData_ff;

	// ----------------------------------------
	// strap capture one edge after reset release
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			strapLoad_ff <= 1'b1;
		end else begin
			strapLoad_ff <= 1'b0;
		end
	end

	// function select register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			led0Fn_ff <= FN_DUAL2;
			led1Fn_ff <= `LEDIC_RST_FN1;
		end else if (strapLoad_ff) begin
			led0Fn_ff <= (ledConfigStrap == 2'h0) ? FN_DUAL2 : FN_GIG;
		end else if (wbWrite && selFunc && wb_sel_i[0]) begin
			led0Fn_ff <= wb_dat_i[`LEDIC_FN0_LSB +: 4];
			led1Fn_ff <= wb_dat_i[`LEDIC_FN1_LSB +: 4];
		end
	end

	// polarity and mix register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mix0_ff <= `LEDIC_MIX_FULL;
			mix1_ff <= `LEDIC_MIX_FULL;
			ledPol_ff <= `LEDIC_RST_POL;
		end else if (strapLoad_ff) begin
			mix0_ff <= ledConfigStrap[1] ? `LEDIC_MIX_FULL : 4'h4;
			mix1_ff <= ledConfigStrap[1] ? `LEDIC_MIX_FULL : 4'h4;
		end else if (wbWrite && selPol) begin
			if (wb_sel_i[0]) begin
				ledPol_ff <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				mix0_ff <= wb_dat_i[`LEDIC_MIX0_LSB +: 4];
				mix1_ff <= wb_dat_i[`LEDIC_MIX1_LSB +: 4];
			end
		end
	end

	// timer control register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			forceInt_ff <= 1'b0;
			stretch_ff <= `LEDIC_RST_STRETCH;
			irqPol_ff <= 1'b0;
			blinkRate_ff <= 3'h1;
			spdOff_ff <= `LEDIC_RST_SPD;
			spdOn_ff <= `LEDIC_RST_SPD;
		end else if (strapLoad_ff) begin
			irqPol_ff <= irqPolarityStrap;
			blinkRate_ff <= (ledConfigStrap == 2'h1) ? 3'h0 : 3'h1;
		end else if (wbWrite && selTmr) begin
			if (wb_sel_i[1]) begin
				forceInt_ff <= wb_dat_i[`LEDIC_FORCE_INT_BIT];
				stretch_ff <= wb_dat_i[`LEDIC_STRETCH_LSB +: 3];
				irqPol_ff <= wb_dat_i[`LEDIC_INTPOL_BIT];
				blinkRate_ff <= wb_dat_i[`LEDIC_BLINK_LSB +: 3];
			end
			if (wb_sel_i[0]) begin
				spdOff_ff <= wb_dat_i[`LEDIC_SPD_OFF_LSB +: 2];
				spdOn_ff <= wb_dat_i[`LEDIC_SPD_ON_LSB +: 2];
			end
		end
	end

	// ----------------------------------------
	// interrupt pins
	// ----------------------------------------
	logic irqActive;

	assign irqActive = forceInt_ff || phyIrqReq;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phyIrqOutHigh <= 1'b0;
			phyIrqOutLow <= 1'b1;
		end else begin
			phyIrqOutHigh <= !irqPol_ff && irqActive;
			phyIrqOutLow <= !(irqPol_ff && irqActive);
		end
	end

	// ----------------------------------------
	// period tables in milliseconds
	// ----------------------------------------
	function automatic ledic_ms_t spdMs(input logic [1:0] code);
		unique case (code)
			2'h0: spdMs = 12'd84;
			2'h1: spdMs = 12'd170;
			2'h2: spdMs = 12'd340;
			2'h3: spdMs = 12'd670;
		endcase
	endfunction

	// half of the blink period; reserved codes take the slowest rate
	function automatic ledic_ms_t blinkHalfMs(input logic [2:0] code);
		case (code)
			3'h0: blinkHalfMs = 12'd21;
			3'h1: blinkHalfMs = 12'd42;
			3'h2: blinkHalfMs = 12'd85;
			3'h3: blinkHalfMs = 12'd170;
			default: blinkHalfMs = 12'd335;
		endcase
	endfunction

	// lower end of each stretch range
	function automatic ledic_ms_t stretchMs(input logic [2:0] code);
		unique case (code)
			3'h0: stretchMs = 12'd0;
			3'h1: stretchMs = 12'd21;
			3'h2: stretchMs = 12'd42;
			3'h3: stretchMs = 12'd84;
			3'h4: stretchMs = 12'd170;
			3'h5: stretchMs = 12'd340;
			3'h6: stretchMs = 12'd670;
			3'h7: stretchMs = 12'd1300;
		endcase
	endfunction

	// ----------------------------------------
	// timing sources
	// ----------------------------------------
	logic msTick;
	logic blinkBusy;
	logic blinkDone;
	logic blinkPh_ff;
	logic activity;
	logic actStretchBusy;
	logic actShown;

	ledic_tick_gen #(
		.MS_CYCLES(MS_CYCLES)
	) u_tick (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.restart(swRst),
		.msTick(msTick)
	);

	ledic_ms_timer u_blink (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.msTick(msTick),
		.start(!blinkBusy || blinkDone || swRst),
		.period(blinkHalfMs(blinkRate_ff)),
		.busy(blinkBusy),
		.done(blinkDone)
	);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			blinkPh_ff <= 1'b0;
		end else if (swRst) begin
			blinkPh_ff <= 1'b0;
		end else if (blinkDone) begin
			blinkPh_ff <= !blinkPh_ff;
		end
	end

	assign activity = rxActive || txActive;

	ledic_ms_timer u_stretch (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.msTick(msTick),
		.start(activity || swRst),
		.period(swRst ? 12'd0 : stretchMs(stretch_ff)),
		.busy(actStretchBusy),
		.done()
	);

	assign actShown = activity || actStretchBusy;

	// ----------------------------------------
	// speed burst sequencer
	// ----------------------------------------
	ledic_burst_e burst_ff;
	ledic_burst_e nxt_burst;
	logic [1:0] burstLeft_ff;
	logic [1:0] nxt_burstLeft;
	logic spdStart;
	ledic_ms_t spdPeriod;
	logic spdDone;
	logic [1:0] blinksForSpeed;

	assign blinksForSpeed = (linkSpeed == 2'h2) ? 2'h3 : (linkSpeed == 2'h1) ? 2'h2 : 2'h1;

	always_comb begin
		nxt_burst = burst_ff;
		nxt_burstLeft = burstLeft_ff;
		spdStart = 1'b0;
		spdPeriod = spdMs(spdOn_ff);
		if (!linkUp) begin
			nxt_burst = SB_IDLE;
		end else begin
			unique case (burst_ff)
				SB_IDLE: begin
					nxt_burst = SB_ON;
					nxt_burstLeft = blinksForSpeed;
					spdStart = 1'b1;
				end
				SB_ON: begin
					if (spdDone) begin
						nxt_burst = SB_OFF;
						spdStart = 1'b1;
						spdPeriod = spdMs(spdOff_ff);
					end
				end
				SB_OFF: begin
					if (spdDone) begin
						spdStart = 1'b1;
						if (burstLeft_ff > 2'h1) begin
							nxt_burst = SB_ON;
							nxt_burstLeft = burstLeft_ff - 2'h1;
						end else begin
							nxt_burst = SB_GAP;
							spdPeriod = spdMs(2'h3);
						end
					end
				end
				SB_GAP: begin
					if (spdDone) begin
						nxt_burst = SB_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			burst_ff <= SB_IDLE;
			burstLeft_ff <= 2'h0;
		end else if (swRst) begin
			burst_ff <= SB_IDLE;
			burstLeft_ff <= 2'h0;
		end else begin
			burst_ff <= nxt_burst;
			burstLeft_ff <= nxt_burstLeft;
		end
	end

	ledic_ms_timer u_speed (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.msTick(msTick),
		.start(spdStart),
		.period(spdPeriod),
		.busy(),
		.done(spdDone)
	);

	// ----------------------------------------
	// bi-colour blend
	// ----------------------------------------
	logic [2:0] pwm_ff;
	logic mixOn0;
	logic mixOn1;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwm_ff <= 3'h0;
		end else begin
			pwm_ff <= pwm_ff + 3'h1;
		end
	end

	assign mixOn0 = {1'b0, pwm_ff} < mix0_ff;
	assign mixOn1 = {1'b0, pwm_ff} < mix1_ff;

	// ----------------------------------------
	// function decode
	// ----------------------------------------
	logic gigLink;
	logic dualMode;
	logic [NUM_LEDS-1:0] ledLit;
	logic led0Single;
	logic led1Single;
	logic dualA;
	logic dualB;

	assign gigLink = linkUp && linkSpeed == 2'h2;
	assign dualMode = led0Fn_ff == FN_DUAL1 || led0Fn_ff == FN_DUAL2 || led0Fn_ff == FN_DUAL4;

	always_comb begin
		led0Single = 1'b0;
		case (led0Fn_ff)
			FN_LINK: led0Single = linkUp;
			FN_LINK_ACT: led0Single = linkUp && !(actShown && blinkPh_ff);
			FN_SPEED_BURST: led0Single = burst_ff == SB_ON;
			FN_ACT_ON: led0Single = actShown;
			FN_ACT_BLINK: led0Single = actShown && blinkPh_ff;
			FN_TX_ON: led0Single = txActive;
			FN_COPPER: led0Single = linkUp && linkCopper;
			FN_GIG: led0Single = gigLink;
			FN_FORCE_OFF: led0Single = 1'b0;
			FN_FORCE_BLINK: led0Single = blinkPh_ff;
			default: led0Single = 1'b0;
		endcase
	end

	always_comb begin
		led1Single = 1'b0;
		case (led1Fn_ff)
			FN_LINK_ACT: led1Single = linkUp && !(actShown && blinkPh_ff);
			FN_ACT_ON: led1Single = actShown;
			FN_ACT_BLINK: led1Single = actShown && blinkPh_ff;
			FN_COPPER: led1Single = linkUp && linkSpeed != 2'h0;
			FN_GIG: led1Single = linkUp && linkSpeed == 2'h1;
			4'b1001: led1Single = 1'b1;
			4'b1011: led1Single = blinkPh_ff;
			default: led1Single = 1'b0;
		endcase
	end

	always_comb begin
		dualA = 1'b0;
		dualB = 1'b0;
		unique case (led0Fn_ff)
			FN_DUAL1: begin
				dualA = gigLink;
				dualB = linkUp && !gigLink;
			end
			FN_DUAL2: begin
				dualA = gigLink && !(actShown && blinkPh_ff);
				dualB = linkUp && !gigLink && !(actShown && blinkPh_ff);
			end
			FN_DUAL4: begin
				dualA = linkUp && mixOn0;
				dualB = linkUp && mixOn1;
			end
			default: begin
				dualA = 1'b0;
				dualB = 1'b0;
			end
		endcase
	end

	always_comb begin
		ledLit = '0;
		ledLit[0] = dualMode ? dualA : led0Single;
		if (dualMode) begin
			ledLit[1] = dualB;
		end else if (ledPol_ff[3:2] == 2'h3) begin
			ledLit[1] = linkUp;
		end else begin
			ledLit[1] = led1Single;
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// state then polarity
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LEDS; gi++) begin : g_pin
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					ledOut[gi] <= 1'b1;
					ledOe[gi] <= 1'b1;
				end else if (ledLit[gi]) begin
					ledOut[gi] <= ledPol_ff[2*gi];
					ledOe[gi] <= 1'b1;
				end else begin
					ledOut[gi] <= ledPol_ff[2*gi+1] ? 1'b0 : !ledPol_ff[2*gi];
					ledOe[gi] <= !ledPol_ff[2*gi+1];
				end
			end
		end
	endgenerate

endmodule

// ==== verif/ledic_core_props.sv ====
// concurrent checks on the led indicator core ports
`timescale 1ns/10ps
module ledic_core_props
	import ledic_pkg::*;
#(
	parameter int NUM_LEDS = 2
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pins
	input wire logic [NUM_LEDS-1:0] ledOut,
	input wire logic [NUM_LEDS-1:0] ledOe,
	input wire logic phyIrqReq,
	input wire logic phyIrqOutHigh,
	input wire logic phyIrqOutLow
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic taken;
	logic rdAck;
	assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rdAck = wb_ack_o && !wb_we_i;
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_delay_a: assert property (taken |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	rdata_hold_a: assert property (!(taken && !wb_we_i) |=> $stable(wb_dat_o))
		else $error("read data changed without a read");
	unmapped_zero_a: assert property (rdAck && !(wb_adr_i inside {8'h40, 8'h44, 8'h48})
		|-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
	timer_rsvd_a: assert property (rdAck && wb_adr_i == 8'h48
		|-> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[7:4] == 4'h0) else $error("timer reserved bits set");
	float_low_a: assert property ((ledOut & ~ledOe) == '0)
		else $error("undriven led pin not low");
	irq_single_a: assert property (!(phyIrqOutHigh && !phyIrqOutLow))
		else $error("both interrupt pins active");
	irq_req_a: assert property (phyIrqReq |=> phyIrqOutHigh || !phyIrqOutLow)
		else $error("interrupt request not shown on pins");
	cover property (taken && wb_we_i);
	cover property (rdAck);
	cover property (!ledOe[0]);
	cover property (!phyIrqOutLow);
endmodule

bind ledic_core ledic_core_props #(.NUM_LEDS(NUM_LEDS)) u_ledic_core_props (
	.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.ledOut(ledOut), .ledOe(ledOe), .phyIrqReq(phyIrqReq), .phyIrqOutHigh(phyIrqOutHigh),
	.phyIrqOutLow(phyIrqOutLow)
);

// ==== verif/ledic_led_board.sv ====
// board model: indicator leds with a pull-up on each led pin
`timescale 1ns/10ps
module ledic_led_board #(
	parameter int NUM_LEDS = 2
) (
	// pins from the device
	input wire logic [NUM_LEDS-1:0] ledOut,
	input wire logic [NUM_LEDS-1:0] ledOe,
	// pad levels on the board
	output logic [NUM_LEDS-1:0] padLevel
);
	always_comb begin
		for (int i = 0; i < NUM_LEDS; i++) begin
			padLevel[i] = ledOe[i] ? ledOut[i] : 1'b1;
		end
	end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the led indicator core
`timescale 1ns/10ps
module testbench
	import ledic_pkg::*;
;
	logic core_clk = 1'b0, sys_rst = 1'b0, swRst = 1'b0, irqPolarityStrap = 1'b0;
	logic [1:0] ledConfigStrap = 2'h0, linkSpeed = 2'h0;
	logic linkUp = 1'b0, linkCopper = 1'b0, rxActive = 1'b0, txActive = 1'b0, phyIrqReq = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic wb_ack_o, phyIrqOutHigh, phyIrqOutLow, prev;
	logic [1:0] ledOut, ledOe, padLevel, exp;
	logic [12:0] r;
	int miscompares = 0, numChecks = 0, cycles = 0, n, k;
	// fn, polarity, {link, copper, speed, rx, tx}, lit
	localparam logic [12:0] ROWS [12] = '{{4'h0, 2'h1, 6'h20, 1'h1}, {4'h0, 2'h2, 6'h00, 1'h0},
		{4'h3, 2'h1, 6'h02, 1'h1}, {4'h3, 2'h1, 6'h00, 1'h0}, {4'h5, 2'h3, 6'h01, 1'h1},
		{4'h5, 2'h3, 6'h02, 1'h0}, {4'h6, 2'h0, 6'h30, 1'h1}, {4'h6, 2'h0, 6'h20, 1'h0},
		{4'h7, 2'h1, 6'h28, 1'h1}, {4'h7, 2'h1, 6'h24, 1'h0}, {4'h8, 2'h1, 6'h22, 1'h0},
		{4'h1, 2'h1, 6'h20, 1'h1}};
	localparam logic [2:0] STRAPS [3] = '{3'h0, 3'h6, 3'h3};
	localparam logic [15:0] EXPF [3] = '{16'h001E, 16'h0017, 16'h0017};
	localparam logic [15:0] EXPM [3] = '{16'h4400, 16'h8800, 16'h4400};
	localparam logic [15:0] EXPT [3] = '{16'h4105, 16'h4105, 16'h4805};
	// timer value, request, expected {high pin, low pin}
	localparam logic [18:0] IRQS [5] = '{{16'h8805, 1'h0, 2'h0}, {16'h0805, 1'h1, 2'h0},
		{16'h0805, 1'h0, 2'h1}, {16'h8005, 1'h0, 2'h3}, {16'h0005, 1'h0, 2'h1}};

	ledic_core #(.MS_CYCLES(5), .NUM_LEDS(2)) u_ledic_core (.core_clk(core_clk),
		.sys_rst(sys_rst), .swRst(swRst), .ledConfigStrap(ledConfigStrap),
		.irqPolarityStrap(irqPolarityStrap), .linkUp(linkUp), .linkCopper(linkCopper),
		.linkSpeed(linkSpeed), .rxActive(rxActive), .txActive(txActive), .phyIrqReq(phyIrqReq),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ledOut(ledOut), .ledOe(ledOe), .phyIrqOutHigh(phyIrqOutHigh),
		.phyIrqOutLow(phyIrqOutLow));
	ledic_led_board #(.NUM_LEDS(2)) u_ledic_led_board (.ledOut(ledOut), .ledOe(ledOe),
		.padLevel(padLevel));

	always #50 core_clk = ~core_clk;

	task automatic results;
		if (miscompares == 0 && numChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			results();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		numChecks++;
		if (seen !== want) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask

	// classic single cycle, held until ack is sampled
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [15:0] dat);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h3;
		wb_dat_i <= {16'h0000, dat};
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic rdChk(input logic [7:0] adr, input logic [15:0] want);
		xfer(1'b0, adr, 16'h0000);
		chk(rd, {16'h0000, want});
	endtask

	function automatic logic [1:0] ledExp(input logic on, input logic [1:0] pol);
		if (on) return {1'b1, pol[0]};
		if (pol[1]) return 2'h0;
		return {1'b1, ~pol[0]};
	endfunction

	initial begin
		for (int i = 0; i < 3; i++) begin
			{ledConfigStrap, irqPolarityStrap} <= STRAPS[i];
			sys_rst <= 1'b1;
			repeat (20) @(posedge core_clk);
			sys_rst <= 1'b0;
			repeat (2) @(posedge core_clk);
			rdChk(8'h40, EXPF[i]);
			rdChk(8'h44, EXPM[i]);
			rdChk(8'h48, EXPT[i]);
		end
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, 8'h48, IRQS[i][18:3]);
			phyIrqReq <= IRQS[i][2];
			repeat (3) @(posedge core_clk);
			chk(32'({phyIrqOutHigh, phyIrqOutLow}), 32'(IRQS[i][1:0]));
		end
		xfer(1'b1, 8'h40, 16'h0013);
		swRst <= 1'b1;
		@(posedge core_clk);
		swRst <= 1'b0;
		rdChk(8'h40, 16'h0013);
		xfer(1'b1, 8'h4C, 16'hFFFF);
		rdChk(8'h4C, 16'h0000);
		rdChk(8'h48, 16'h0005);
		xfer(1'b1, 8'h48, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			r = ROWS[i];
			xfer(1'b1, 8'h40, {8'h00, 4'h1, r[12:9]});
			xfer(1'b1, 8'h44, {8'h44, 6'h00, r[8:7]});
			{linkUp, linkCopper, linkSpeed, rxActive, txActive} <= r[6:1];
			repeat (3) @(posedge core_clk);
			exp = ledExp(r[0], r[8:7]);
			chk(32'({ledOe[0], ledOut[0]}), 32'(exp));
			chk(32'(padLevel[0]), 32'(exp[1] ? exp[0] : 1'b1));
		end
		xfer(1'b1, 8'h44, 16'h2405);
		xfer(1'b1, 8'h40, 16'h000C);
		{linkUp, linkSpeed} <= 3'h6;
		repeat (3) @(posedge core_clk);
		chk(32'(ledOut), 32'h1);
		linkSpeed <= 2'h1;
		repeat (3) @(posedge core_clk);
		chk(32'(ledOut), 32'h2);
		xfer(1'b1, 8'h40, 16'h000F);
		repeat (3) @(posedge core_clk);
		n = 0;
		k = 0;
		repeat (8) begin
			@(posedge core_clk);
			if (ledOut[0] === 1'b1) n++;
			if (ledOut[1] === 1'b1) k++;
		end
		chk(32'(n), 32'h4);
		chk(32'(k), 32'h2);
		xfer(1'b1, 8'h48, 16'h1000);
		xfer(1'b1, 8'h40, 16'h0013);
		rxActive <= 1'b1;
		@(posedge core_clk);
		rxActive <= 1'b0;
		repeat (50) @(posedge core_clk);
		chk(32'(ledOut[0]), 32'h1);
		repeat (100) @(posedge core_clk);
		chk(32'(ledOut[0]), 32'h0);
		xfer(1'b1, 8'h40, 16'h0088);
		xfer(1'b1, 8'h44, 16'h440D);
		{linkUp, rxActive} <= 2'h2;
		repeat (3) @(posedge core_clk);
		chk(32'({ledOe[1], ledOut[1]}), 32'h3);
		linkUp <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(32'({ledOe[1], ledOut[1]}), 32'h0);
		xfer(1'b1, 8'h40, 16'h0019);
		n = 0;
		prev = ledOut[0];
		repeat (500) begin
			@(posedge core_clk);
			if (ledOut[0] !== prev) n++;
			prev = ledOut[0];
		end
		chk(32'(n > 2), 32'h1);
		xfer(1'b1, 8'h40, 16'h0012);
		for (int s = 0; s < 3; s++) begin
			linkUp <= 1'b0;
			repeat (20) @(posedge core_clk);
			linkSpeed <= 2'(s);
			linkUp <= 1'b1;
			k = 0;
			while (ledOut[0] !== 1'b1 && k < 8000) begin
				@(posedge core_clk);
				k++;
			end
			chk(32'(k < 8000), 32'h1);
			n = 1;
			prev = 1'b1;
			// window shorter than one burst plus gap
			repeat (3500) begin
				@(posedge core_clk);
				if (ledOut[0] === 1'b1 && prev !== 1'b1) n++;
				prev = ledOut[0];
			end
			chk(32'(n), 32'(s + 1));
		end
		results();
	end
endmodule
